// *** logic/serial_port_unit.sv ***
`default_nettype none
`include "serial_port_map.svh"
// Function
// - Holding write with transmit enable and break request starts a break, data ignored.
// - Byte written after dummy waits; break end clears request, then byte is sent.
// - Empty flag rises when holding register empties; software writes only then.
// - Break seen when receive done, framing error set and received byte zero.
// - Wake mode flags activity on a falling line edge, then receives next byte normally.
// - Synchronous characters carry no start or stop bits.
// - One clock and one shared data line; never transmit and receive together.
// - Master drives shift clock; clock driver enabled automatically in sync master.
// - Exactly one clock cycle per data bit, none extra.
// - Data changes on leading clock edge, stable through trailing edge.
// - Polarity set: idle high, falling leads; cleared: idle low, rising leads.
// - Sync master transmit drives data pin; data and clock drivers enabled.
// - Character waits while shift busy; moves across and shifts at once when empty.
// - Shift register not visible to software; only holding register.
// - Master makes the shift clock; slaves shift on it.
// - Break is start bit, twelve zero bits, stop bit.
// - Wake enable cleared by the rising line edge ending the break.
// - Shift empty status shows idle or active, also during break.
module serial_port_unit
  import serial_port_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [2:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic CK_O,
  output logic CK_OE,
  input wire logic DT_I,
  output logic DT_O,
  output logic DT_OE
);
  state_t s_reg;
  state_t s_next;
  logic os_tick;

  // Oversample tick at sixteen per bit time
  baud_tick #(.DIV_W(16)) u_baud (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .run(s_reg.rx_ctrl.port_en),
    .divisor(s_reg.divisor),
    .tick(os_tick)
  );

  always_comb begin
    logic wr_hold;
    logic rd_data;
    logic line_fall;
    logic line_rise;
    logic master_sync;
    logic rx_on;
    s_next = s_reg;
    master_sync = 1'b0;
    rx_on = 1'b0;
    wr_hold = REG_WR && (REG_ADDR == `SP_HOLD_OFS);
    rd_data = REG_RD && (REG_ADDR == `SP_RX_DATA_OFS);
    line_fall = s_reg.dt_prev && !s_reg.dt_sync;
    line_rise = !s_reg.dt_prev && s_reg.dt_sync;

    // Two-stage sync of the data pin, edges seen only after stage two
    s_next.dt_meta = DT_I;
    s_next.dt_sync = s_reg.dt_meta;
    s_next.dt_prev = s_reg.dt_sync;

    // Software writes to control registers
    if (REG_WR) begin
      unique case (REG_ADDR)
        `SP_TX_CTRL_OFS: begin
          s_next.tx_ctrl.transmit_enable_bit = REG_WDATA[`SP_TRANSMIT_ENABLE_BIT_BIT];
          s_next.tx_ctrl.break_send_request = REG_WDATA[`SP_BREAK_SEND_REQUEST_BIT];
          s_next.tx_ctrl.sync_mode = REG_WDATA[`SP_SYNC_BIT];
          s_next.tx_ctrl.clock_source_select = REG_WDATA[`SP_CLOCK_SOURCE_SELECT_BIT];
          s_next.tx_ctrl.ninth_en = REG_WDATA[`SP_NINTH_EN_BIT];
          s_next.tx_ctrl.ninth_val = REG_WDATA[`SP_NINTH_VAL_BIT];
        end
        `SP_RX_CTRL_OFS: begin
          s_next.rx_ctrl.port_en = REG_WDATA[`SP_PORT_EN_BIT];
          s_next.rx_ctrl.single_receive_enable = REG_WDATA[`SP_SINGLE_RECEIVE_ENABLE_BIT];
          s_next.rx_ctrl.continuous_receive_enable = REG_WDATA[`SP_CONTINUOUS_RECEIVE_ENABLE_BIT];
        end
        `SP_BAUD_CTRL_OFS: begin
          s_next.baud_ctrl.polarity = REG_WDATA[`SP_POL_BIT];
          s_next.baud_ctrl.wake_en = REG_WDATA[`SP_WAKE_BIT];
          s_next.baud_ctrl.abd_en = REG_WDATA[`SP_ABD_BIT];
        end
        `SP_DIV_LOW_OFS: s_next.divisor[7:0] = REG_WDATA;
        `SP_DIV_HIGH_OFS: s_next.divisor[15:8] = REG_WDATA;
        default: ;
      endcase
    end

    // Holding write; a break is armed once, so the next byte queues normally
    if (wr_hold) begin
      s_next.hold_data = REG_WDATA;
      s_next.hold_full = 1'b1;
      s_next.hold_break = s_reg.tx_ctrl.transmit_enable_bit && s_reg.tx_ctrl.break_send_request &&
        !s_reg.break_active && !s_reg.hold_break;
    end

    master_sync = s_next.rx_ctrl.port_en && s_next.tx_ctrl.sync_mode && s_next.tx_ctrl.clock_source_select;

    // Transmit engine
    unique case (s_reg.tx_state)
      TX_IDLE: begin
        s_next.line = 1'b1;
        s_next.sclk = s_next.baud_ctrl.polarity;
        // Move across as soon as the shift register is free
        if (s_next.hold_full && s_next.tx_ctrl.transmit_enable_bit && s_next.rx_ctrl.port_en) begin
          s_next.hold_full = 1'b0;
          s_next.tx_phase = `SP_PHASE_LEAD;
          if (s_next.tx_ctrl.sync_mode) begin
            s_next.tx_state = TX_SYNC;
            // LSB first, ninth bit after the byte, no framing bits
            s_next.frame = {5'h00, s_next.tx_ctrl.ninth_val, s_next.hold_data};
            s_next.tx_bits = s_next.tx_ctrl.ninth_en ? `SP_LEN_SYNC9 : `SP_LEN_SYNC8;
          end else if (s_next.hold_break) begin
            s_next.tx_state = TX_ASYNC;
            s_next.break_active = 1'b1;
            s_next.hold_break = 1'b0;
            s_next.frame = {1'b1, `SP_BREAK_ZEROS, 1'b0};
            s_next.tx_bits = `SP_LEN_BREAK;
          end else begin
            s_next.tx_state = TX_ASYNC;
            s_next.frame = s_next.tx_ctrl.ninth_en ?
              {3'h7, 1'b1, s_next.tx_ctrl.ninth_val, s_next.hold_data, 1'b0} :
              {4'hF, 1'b1, s_next.hold_data, 1'b0};
            s_next.tx_bits = s_next.tx_ctrl.ninth_en ? `SP_LEN_ASYNC9 : `SP_LEN_ASYNC8;
          end
        end
      end
      TX_ASYNC, TX_SYNC: begin
        if (os_tick) begin
          s_next.tx_phase = s_reg.tx_phase + 4'h1;
          if (s_reg.tx_phase == `SP_PHASE_LEAD) begin
            // New bit and leading clock edge together
            s_next.line = s_reg.frame[0];
            s_next.frame = {1'b0, s_reg.frame[13:1]};
            if (s_reg.tx_state == TX_SYNC) begin
              s_next.sclk = !s_reg.baud_ctrl.polarity;
            end
          end
          if (s_reg.tx_phase == `SP_PHASE_TRAIL && s_reg.tx_state == TX_SYNC) begin
            s_next.sclk = s_reg.baud_ctrl.polarity;
          end
          if (s_reg.tx_phase == `SP_PHASE_LAST) begin
            if (s_reg.tx_bits == 4'h1) begin
              // No clock beyond the last bit
              s_next.tx_state = TX_IDLE;
              if (s_reg.break_active) begin
                s_next.break_active = 1'b0;
                s_next.tx_ctrl.break_send_request = 1'b0;
              end
            end else begin
              s_next.tx_bits = s_reg.tx_bits - 4'h1;
            end
          end
        end
      end
      default: s_next.tx_state = TX_IDLE;
    endcase

    // Dropping transmit enable or the port aborts the character in flight
    if (!s_next.tx_ctrl.transmit_enable_bit || !s_next.rx_ctrl.port_en) begin
      s_next.tx_state = TX_IDLE;
      s_next.hold_full = 1'b0;
      s_next.hold_break = 1'b0;
      s_next.break_active = 1'b0;
    end

    // Reading received data clears the done flag; a new event in the same cycle wins
    if (rd_data) begin
      s_next.rx_done = 1'b0;
    end

    // Wake on activity: falling edge flags, rising edge ends the break
    if (s_reg.baud_ctrl.wake_en && !s_reg.tx_ctrl.sync_mode && s_reg.rx_ctrl.port_en) begin
      if (line_fall) begin
        s_next.rx_done = 1'b1;
        s_next.wake_seen = 1'b1;
      end
      if (line_rise && s_reg.wake_seen) begin
        s_next.baud_ctrl.wake_en = 1'b0;
        s_next.wake_seen = 1'b0;
      end
    end else begin
      s_next.wake_seen = 1'b0;
    end

    // Async receiver, idle while wake mode holds off normal reception
    rx_on = s_reg.rx_ctrl.port_en && s_reg.rx_ctrl.continuous_receive_enable && !s_reg.tx_ctrl.sync_mode &&
      !s_reg.baud_ctrl.wake_en;
    if (!rx_on) begin
      s_next.rx_busy = 1'b0;
    end else if (!s_reg.rx_busy) begin
      if (line_fall) begin
        s_next.rx_busy = 1'b1;
        s_next.rx_phase = `SP_PHASE_LEAD;
        s_next.rx_idx = 4'h0;
      end
    end else if (os_tick) begin
      s_next.rx_phase = s_reg.rx_phase + 4'h1;
      if (s_reg.rx_phase == `SP_PHASE_SAMPLE) begin
        s_next.rx_idx = s_reg.rx_idx + 4'h1;
        if (s_reg.rx_idx == 4'h0) begin
          // Glitch rather than a start bit
          s_next.rx_busy = !s_reg.dt_sync;
        end else if (s_reg.rx_idx == `SP_RX_STOP_IDX) begin
          s_next.rx_busy = 1'b0;
          s_next.rx_data = s_reg.rx_shift;
          s_next.rx_done = 1'b1;
          s_next.framing_error_bit = !s_reg.dt_sync;
          s_next.break_seen = !s_reg.dt_sync && (s_reg.rx_shift == `SP_BYTE_RST);
        end else begin
          s_next.rx_shift = {s_reg.dt_sync, s_reg.rx_shift[7:1]};
        end
      end
    end

    // Read data, presented the cycle after the strobe; shift register unmapped
    s_next.rdata = `SP_BYTE_RST;
    if (REG_RD) begin
      unique case (REG_ADDR)
        `SP_TX_CTRL_OFS: begin
          s_next.rdata[`SP_TRANSMIT_ENABLE_BIT_BIT] = s_reg.tx_ctrl.transmit_enable_bit;
          s_next.rdata[`SP_BREAK_SEND_REQUEST_BIT] = s_reg.tx_ctrl.break_send_request;
          s_next.rdata[`SP_SYNC_BIT] = s_reg.tx_ctrl.sync_mode;
          s_next.rdata[`SP_CLOCK_SOURCE_SELECT_BIT] = s_reg.tx_ctrl.clock_source_select;
          s_next.rdata[`SP_NINTH_EN_BIT] = s_reg.tx_ctrl.ninth_en;
          s_next.rdata[`SP_NINTH_VAL_BIT] = s_reg.tx_ctrl.ninth_val;
          // A queued byte in its hand-over cycle still counts as busy
          s_next.rdata[`SP_SHIFT_EMPTY_BIT] = (s_reg.tx_state == TX_IDLE) &&
            !s_reg.hold_full;
          s_next.rdata[`SP_TX_EMPTY_BIT] = !s_reg.hold_full;
        end
        `SP_RX_CTRL_OFS: begin
          s_next.rdata[`SP_PORT_EN_BIT] = s_reg.rx_ctrl.port_en;
          s_next.rdata[`SP_SINGLE_RECEIVE_ENABLE_BIT] = s_reg.rx_ctrl.single_receive_enable;
          s_next.rdata[`SP_CONTINUOUS_RECEIVE_ENABLE_BIT] = s_reg.rx_ctrl.continuous_receive_enable;
          s_next.rdata[`SP_FRAMING_ERROR_BIT_BIT] = s_reg.framing_error_bit;
          s_next.rdata[`SP_RX_DONE_BIT] = s_reg.rx_done;
          s_next.rdata[`SP_BREAK_BIT] = s_reg.rx_done && s_reg.break_seen;
        end
        `SP_BAUD_CTRL_OFS: begin
          s_next.rdata[`SP_POL_BIT] = s_reg.baud_ctrl.polarity;
          s_next.rdata[`SP_WAKE_BIT] = s_reg.baud_ctrl.wake_en;
          s_next.rdata[`SP_ABD_BIT] = s_reg.baud_ctrl.abd_en;
        end
        `SP_RX_DATA_OFS: s_next.rdata = s_reg.rx_data;
        `SP_DIV_LOW_OFS: s_next.rdata = s_reg.divisor[7:0];
        `SP_DIV_HIGH_OFS: s_next.rdata = s_reg.divisor[15:8];
        default: ;
      endcase
    end

    // Pin drivers; data driver on in sync master while both receive enables are clear, so no contention
    s_next.ck_oe = s_next.rx_ctrl.port_en && (!s_next.tx_ctrl.sync_mode ||
      s_next.tx_ctrl.clock_source_select);
    s_next.dt_oe = master_sync && !s_next.rx_ctrl.single_receive_enable && !s_next.rx_ctrl.continuous_receive_enable;
    s_next.ck_o = s_next.tx_ctrl.sync_mode ? s_next.sclk : s_next.line;
    s_next.dt_o = s_next.line;
  end

  // Single state register
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      s_reg <= '0;
      s_reg.tx_state <= TX_IDLE;
      s_reg.line <= 1'b1;
      s_reg.dt_meta <= 1'b1;
      s_reg.dt_sync <= 1'b1;
      s_reg.dt_prev <= 1'b1;
      s_reg.ck_o <= 1'b1;
      s_reg.dt_o <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign REG_RDATA = s_reg.rdata;
  assign CK_O = s_reg.ck_o;
  assign CK_OE = s_reg.ck_oe;
  assign DT_O = s_reg.dt_o;
  assign DT_OE = s_reg.dt_oe;
endmodule : serial_port_unit
`default_nettype wire

// *** logic/serial_port_map.svh ***
`ifndef SERIAL_PORT_MAP_SVH
`define SERIAL_PORT_MAP_SVH
// Register offsets
`define SP_TX_CTRL_OFS 3'h0
`define SP_RX_CTRL_OFS 3'h1
`define SP_BAUD_CTRL_OFS 3'h2
`define SP_HOLD_OFS 3'h3
`define SP_RX_DATA_OFS 3'h4
`define SP_DIV_LOW_OFS 3'h5
`define SP_DIV_HIGH_OFS 3'h6
// Transmit control and status bits
`define SP_TRANSMIT_ENABLE_BIT_BIT 0
`define SP_BREAK_SEND_REQUEST_BIT 1
`define SP_SYNC_BIT 2
`define SP_CLOCK_SOURCE_SELECT_BIT 3
`define SP_NINTH_EN_BIT 4
`define SP_NINTH_VAL_BIT 5
`define SP_SHIFT_EMPTY_BIT 6
`define SP_TX_EMPTY_BIT 7
// Receive control and status bits
`define SP_PORT_EN_BIT 0
`define SP_SINGLE_RECEIVE_ENABLE_BIT 1
`define SP_CONTINUOUS_RECEIVE_ENABLE_BIT 2
`define SP_FRAMING_ERROR_BIT_BIT 3
`define SP_RX_DONE_BIT 4
`define SP_BREAK_BIT 5
// Baud control bits
`define SP_POL_BIT 0
`define SP_WAKE_BIT 1
`define SP_ABD_BIT 2
// Reset values
`define SP_BYTE_RST 8'h00
`define SP_DIV_RST 16'h0000
`define SP_FRAME_RST 14'h0000
// Bit timing in oversample ticks
`define SP_PHASE_LEAD 4'h0
`define SP_PHASE_SAMPLE 4'h7
`define SP_PHASE_TRAIL 4'h8
`define SP_PHASE_LAST 4'hF
// Frame lengths in bits
`define SP_LEN_ASYNC8 4'hA
`define SP_LEN_ASYNC9 4'hB
`define SP_LEN_BREAK 4'hE
`define SP_LEN_SYNC8 4'h8
`define SP_LEN_SYNC9 4'h9
`define SP_RX_STOP_IDX 4'h9
`define SP_BREAK_ZEROS 12'h000
`endif

// *** logic/serial_port_pkg.sv ***
`default_nettype none
package serial_port_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} tx_state_t;

  typedef struct packed {
    logic transmit_enable_bit;
    logic break_send_request;
    logic sync_mode;
    logic clock_source_select;
    logic ninth_en;
    logic ninth_val;
  } tx_ctrl_t;

  typedef struct packed {
    logic port_en;
    logic single_receive_enable;
    logic continuous_receive_enable;
  } rx_ctrl_t;

  typedef struct packed {
    logic polarity;
    logic wake_en;
    logic abd_en;
  } baud_ctrl_t;

  typedef struct packed {
    tx_ctrl_t tx_ctrl;
    rx_ctrl_t rx_ctrl;
    baud_ctrl_t baud_ctrl;
    logic [15:0] divisor;
    logic [7:0] hold_data;
    logic hold_full;
    logic hold_break;
    tx_state_t tx_state;
    logic break_active;
    logic [13:0] frame;
    logic [3:0] tx_bits;
    logic [3:0] tx_phase;
    logic line;
    logic sclk;
    logic dt_meta;
    logic dt_sync;
    logic dt_prev;
    logic rx_busy;
    logic [3:0] rx_phase;
    logic [3:0] rx_idx;
    logic [7:0] rx_shift;
    logic [7:0] rx_data;
    logic rx_done;
    logic framing_error_bit;
    logic break_seen;
    logic wake_seen;
    logic [7:0] rdata;
    logic ck_o;
    logic ck_oe;
    logic dt_o;
    logic dt_oe;
  } state_t;
endpackage : serial_port_pkg
`default_nettype wire

// *** logic/baud_tick.sv ***
`default_nettype none
`include "serial_port_map.svh"
module baud_tick #(
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [DIV_W-1:0] divisor,
  output logic tick
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } tick_state_t;

  tick_state_t s_reg;
  tick_state_t s_next;

  // Pulse once every divisor+1 cycles; held in reset while the port is off
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (!run) begin
      s_next.cnt = '0;
    end else if (s_reg.cnt >= divisor) begin
      s_next.cnt = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;
endmodule : baud_tick
`default_nettype wire

// *** test/serial_port_unit_sva.sv ***
`default_nettype none
`include "serial_port_map.svh"
module serial_port_unit_sva
  import serial_port_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [2:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic CK_O,
  input wire logic CK_OE,
  input wire logic DT_I,
  input wire logic DT_O,
  input wire logic DT_OE
);
  // One clock domain, so clock and disable are declared once
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  // Pins must be quiet right after reset, whatever was going on before
  a_reset_quiet: assert property (disable iff (1'b0) !RST_N |=>
    (!CK_OE && !DT_OE && DT_O && CK_O && REG_RDATA == 8'h00))
    else $error("outputs not at reset level");
  a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data outside read cycle");
  a_hidden_zero: assert property (REG_RD &&
    (REG_ADDR == `SP_HOLD_OFS || REG_ADDR == 3'h7) |=> REG_RDATA == 8'h00)
    else $error("write-only or unmapped read not zero");
  a_break_flag: assert property (REG_RD && REG_ADDR == `SP_RX_CTRL_OFS |=>
    !REG_RDATA[`SP_BREAK_BIT] || (REG_RDATA[`SP_RX_DONE_BIT] && REG_RDATA[`SP_FRAMING_ERROR_BIT_BIT]))
    else $error("break flag without complete and framing error");
  a_data_needs_ck: assert property (DT_OE |-> CK_OE)
    else $error("data driven without clock driver");
  // A data change on a clock edge must be a leading edge, held to the trailing one
  a_data_stable: assert property (DT_OE && $changed(CK_O) && $changed(DT_O) |=>
    ($stable(DT_O) && DT_OE)[*8])
    else $error("data moved before trailing edge");
  a_rx_stops_dt: assert property (REG_WR && REG_ADDR == `SP_RX_CTRL_OFS &&
    (REG_WDATA[`SP_SINGLE_RECEIVE_ENABLE_BIT] || REG_WDATA[`SP_CONTINUOUS_RECEIVE_ENABLE_BIT]) |-> ##2 !DT_OE)
    else $error("data driven while receive selected");
  a_port_off: assert property (REG_WR && REG_ADDR == `SP_RX_CTRL_OFS &&
    !REG_WDATA[`SP_PORT_EN_BIT] |-> ##2 (!CK_OE && !DT_OE))
    else $error("pins driven with port disabled");
endmodule : serial_port_unit_sva
`default_nettype wire

// *** test/line_partner.sv ***
`default_nettype none
module line_partner (
  input wire logic ck,
  input wire logic dt,
  input wire logic ck_oe,
  input wire logic dt_oe,
  input wire logic pol,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lclk = 1'b0;
  logic [17:0] cap = '0;
  int n_tr = 0;
  initial line = 1'b1;
  // Own 800 ns clock; two periods make one asynchronous bit
  always #400 lclk = ~lclk;
  // Slave shifts only on the master's trailing edge, never a clock of its own
  always @(ck) begin
    if (ck_oe && dt_oe && ck === pol) begin
      cap = {dt, cap[17:1]};
      n_tr++;
    end
  end
  // Frame with start, eight bits LSB first and chosen stop level, then pull-up idle
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge lclk);
      line = f[i];
      @(posedge lclk);
    end
    @(posedge lclk);
    line = 1'b1;
    repeat (2) @(posedge lclk);
  endtask : send
endmodule : line_partner
`default_nettype wire

// *** test/tb_serial_port_unit.sv ***
`default_nettype none
`include "serial_port_map.svh"
module tb_serial_port_unit
  import serial_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic SYS_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [2:0] REG_ADDR = 3'h0;
  logic [7:0] REG_WDATA = 8'h00;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [7:0] REG_RDATA;
  logic CK_O, CK_OE, DT_O, DT_OE, p_line;
  logic pol = 1'b0;
  wire logic DT_I;
  logic [17:0] v;
  logic [7:0] v8;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  // Shared data wire: ours while driving, else the partner's pulled-up line
  assign DT_I = DT_OE ? DT_O : p_line;
  always #50 SYS_CLK = ~SYS_CLK;
  serial_port_unit dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .CK_O(CK_O), .CK_OE(CK_OE), .DT_I(DT_I), .DT_O(DT_O), .DT_OE(DT_OE));
  line_partner partner (.ck(CK_O), .dt(DT_O), .ck_oe(CK_OE), .dt_oe(DT_OE), .pol(pol),
    .line(p_line));

  task automatic chk(input logic [17:0] g, input logic [17:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Bus tasks start just after an edge and end on one, two cycles each
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
    @(posedge SYS_CLK);
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    #1;
    d = REG_RDATA;
    @(posedge SYS_CLK);
  endtask : rd
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(18'(d), 18'(e));
  endtask : rdc
  task automatic idle(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask : idle
  // Sample the asynchronous line mid-bit, 16 cycles per bit at divisor zero
  task automatic acap(input int n, output logic [17:0] b);
    int k;
    b = '0;
    for (k = 0; k < 400 && CK_O !== 1'b0; k++) @(posedge SYS_CLK);
    idle(8);
    for (int i = 0; i < n; i++) begin
      b[i] = CK_O;
      if (i < n - 1) idle(16);
    end
  endtask : acap
  task automatic final_report;
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  // Hang guard, well above the roughly two thousand cycles the run needs
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 10000) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    idle(4);
    RST_N <= 1'b1;
    wr(`SP_DIV_LOW_OFS, 8'h00);
    wr(3'h7, 8'hFF);
    rdc(`SP_TX_CTRL_OFS, 8'hC0);
    for (int a = 1; a < 8; a++) rdc(a[2:0], 8'h00);
    $display("test reset_map done");
    wr(`SP_RX_CTRL_OFS, 8'h01);
    wr(`SP_TX_CTRL_OFS, 8'h03);
    wr(`SP_HOLD_OFS, 8'hA5);
    wr(`SP_HOLD_OFS, 8'h55);
    acap(14, v);
    chk(v, 18'h02000);
    rdc(`SP_TX_CTRL_OFS, 8'h03);
    acap(10, v);
    chk(v, 18'h002AA);
    idle(16);
    rdc(`SP_TX_CTRL_OFS, 8'hC1);
    $display("test break_header done");
    wr(`SP_RX_CTRL_OFS, 8'h05);
    partner.send(8'h00, 1'b0);
    idle(8);
    rdc(`SP_RX_CTRL_OFS, 8'h3D);
    rdc(`SP_RX_DATA_OFS, 8'h00);
    partner.send(8'h3C, 1'b1);
    idle(8);
    rdc(`SP_RX_CTRL_OFS, 8'h15);
    rdc(`SP_RX_DATA_OFS, 8'h3C);
    $display("test break_rx done");
    wr(`SP_BAUD_CTRL_OFS, 8'h06);
    partner.send(8'h00, 1'b0);
    idle(8);
    rdc(`SP_BAUD_CTRL_OFS, 8'h04);
    rdc(`SP_RX_CTRL_OFS, 8'h15);
    rd(`SP_RX_DATA_OFS, v8);
    partner.send(8'hA7, 1'b1);
    idle(8);
    rdc(`SP_RX_CTRL_OFS, 8'h15);
    rdc(`SP_RX_DATA_OFS, 8'hA7);
    $display("test wake done");
    // Synchronous master: polarity 0 with 8 bits, polarity 1 with 9 bits
    for (int p = 0; p < 2; p++) begin
      pol = p[0];
      wr(`SP_RX_CTRL_OFS, 8'h01);
      wr(`SP_BAUD_CTRL_OFS, p ? 8'h01 : 8'h00);
      wr(`SP_TX_CTRL_OFS, p ? 8'h3D : 8'h0D);
      idle(4);
      partner.cap = '0;
      partner.n_tr = 0;
      wr(`SP_HOLD_OFS, 8'hA5);
      wr(`SP_HOLD_OFS, 8'h3C);
      v8 = 8'h00;
      for (int k = 0; k < 300 && !v8[`SP_SHIFT_EMPTY_BIT]; k++) rd(`SP_TX_CTRL_OFS, v8);
      chk(18'(v8), p ? 18'h000FD : 18'h000CD);
      chk(18'(partner.n_tr), p ? 18'h00012 : 18'h00010);
      v = p ? partner.cap : partner.cap >> 2;
      chk(v, p ? {1'b1, 8'h3C, 1'b1, 8'hA5} : 18'h03CA5);
      chk(18'(CK_O), 18'(pol));
      chk(18'({CK_OE, DT_OE}), 18'h00003);
      $display("test sync_tx polarity %0d done", p);
    end
    wr(`SP_RX_CTRL_OFS, 8'h03);
    idle(2);
    chk(18'(DT_OE), 18'h00000);
    wr(`SP_RX_CTRL_OFS, 8'h00);
    idle(2);
    chk(18'({CK_OE, DT_OE}), 18'h00000);
    $display("test sync_off done");
    final_report();
  end
endmodule : tb_serial_port_unit

bind serial_port_unit serial_port_unit_sva chk_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .CK_O(CK_O), .CK_OE(CK_OE), .DT_I(DT_I), .DT_O(DT_O),
  .DT_OE(DT_OE));
`default_nettype wire
